// ===== verilog/universal_shift_unit.sv
// universal shift unit: 8-bit shift register, 4-bit edge counter, clock source select,
// output latch, receive copy and two-wire clock hold.
// assumes control bits arrive as plain ports on ref_clk, pins arrive asynchronously and
// the serial clock pin also feeds link_clk, which should run during reset.
//
// How it works
// - one shift register plus a receive copy
// - msb drives output pin chosen by wire mode
// - output latch changes opposite to sampling edge
// - input always sampled from data input pin
// - counter readable, writable, raises overflow interrupt
// - shift register and counter share clock source
// - external clock counts both edges
// - clock from pin, timer match or strobe
// - start condition can raise an interrupt
// - hold clock low after start or overflow
// - three-wire spi modes zero and one, no select
// - eight clocks exchange both shift registers
// - edge select chooses sample and shift edges
// - load data and enable driver before sampling
// - sixteen edges overflow and set flag
// - overflow interrupt wakes processor from idle
// - flag clear write also loads counter with written count
// - strobed writes toggle pin and count once
// - alternating writes give half system clock
// - slave shifts on external clock, flag completes
// - copy shift register to buffer on completion
// - software write beats simultaneous shift
// - latch half open external, always open internal
`timescale 1ns/1ns
`include "serial_shift_cfg.svh"

module universal_shift_unit
(
    // clocks and reset
    input  wire logic                            ref_clk,
    input  wire logic                            reset,
    input  wire logic                            link_clk,
    // pins
    input  wire logic                            serial_data_in,
    input  wire logic                            serial_clock_level,
    output logic                                 data_out,
    output logic                                 data_out_en,
    output logic                                 sda_out,
    output logic                                 sda_oe,
    output logic                                 serial_clock_out,
    output logic                                 serial_clock_oe,
    // port direction bits
    input  wire logic                            data_out_dir,
    input  wire logic                            clock_pin_dir,
    // configuration
    input  wire serial_shift_pkg::wire_mode_t    wire_mode,
    input  wire logic                            external_clock_select,
    input  wire logic                            clock_edge_select,
    input  wire logic                            start_irq_enable,
    input  wire logic                            overflow_irq_enable,
    // control write strobes and timer match
    input  wire logic                            control_write,
    input  wire logic                            software_clock_strobe,
    input  wire logic                            clock_toggle_strobe,
    input  wire logic                            timer0_match,
    // data and status writes
    input  wire logic                            data_write,
    input  wire serial_shift_pkg::shift_word_t   data_write_value,
    input  wire logic                            status_write,
    input  wire logic                            status_clear_start,
    input  wire logic                            status_clear_overflow,
    input  wire serial_shift_pkg::edge_count_t   status_write_count,
    // read back
    output serial_shift_pkg::shift_word_t        data_shift_register,
    output serial_shift_pkg::shift_word_t        receive_buffer_copy,
    output serial_shift_pkg::edge_count_t        counter_value,
    output logic                                 counter_overflow_flag,
    output logic                                 start_flag,
    output logic                                 overflow_irq,
    output logic                                 start_irq
);

    // link domain: reset brought over, edges marked by toggles, data caught per edge
    logic link_reset_meta;
    logic link_reset;
    logic rise_toggle;
    logic fall_toggle;
    logic rise_data;
    logic fall_data;

    always_ff @(posedge link_clk)
    begin
        link_reset_meta <= reset;
        link_reset      <= link_reset_meta;
    end

    always_ff @(posedge link_clk)
    begin
        if (link_reset)
        begin
            rise_toggle <= 1'b0;
            rise_data   <= 1'b0;
        end
        else
        begin
            rise_toggle <= ~rise_toggle;
            rise_data   <= serial_data_in;
        end
    end

    always_ff @(negedge link_clk)
    begin
        if (link_reset)
        begin
            fall_toggle <= 1'b0;
            fall_data   <= 1'b0;
        end
        else
        begin
            fall_toggle <= ~fall_toggle;
            fall_data   <= serial_data_in;
        end
    end

    // crossings into ref_clk
    logic [2:0] rise_sync;
    logic [2:0] fall_sync;
    logic [1:0] rise_data_sync;
    logic [1:0] fall_data_sync;
    logic [1:0] din_sync;
    logic [1:0] scl_sync;
    logic       din_prev;
    logic       sampled;

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            rise_sync      <= 3'h0;
            fall_sync      <= 3'h0;
            rise_data_sync <= 2'h0;
            fall_data_sync <= 2'h0;
            din_sync       <= 2'h3;
            scl_sync       <= 2'h3;
            din_prev       <= 1'b1;
        end
        else
        begin
            rise_sync      <= {rise_sync[1:0], rise_toggle};
            fall_sync      <= {fall_sync[1:0], fall_toggle};
            rise_data_sync <= {rise_data_sync[0], rise_data};
            fall_data_sync <= {fall_data_sync[0], fall_data};
            din_sync       <= {din_sync[0], serial_data_in};
            scl_sync       <= {scl_sync[0], serial_clock_level};
            din_prev       <= din_sync[1];
        end
    end

    // edge and source decode
    wire ext_rise   = rise_sync[2] ^ rise_sync[1];
    wire ext_fall   = fall_sync[2] ^ fall_sync[1];
    wire sample_evt = clock_edge_select ? ext_fall : ext_rise;
    wire shift_evt  = clock_edge_select ? ext_rise : ext_fall;
    wire sample_bit = clock_edge_select ? fall_data_sync[1] : rise_data_sync[1];
    wire sw_clock   = control_write & software_clock_strobe;
    wire toggle_clk = control_write & clock_toggle_strobe;
    wire int_clock  = clock_edge_select ? timer0_match : sw_clock;
    wire two_wire   = wire_mode[1];
    wire hold_on_ovf = (wire_mode == serial_shift_pkg::wire_two_hold);

    wire ext_count  = software_clock_strobe ? toggle_clk : (ext_rise | ext_fall);
    wire count_evt  = external_clock_select ? ext_count : int_clock;
    wire do_shift   = external_clock_select ? shift_evt : int_clock;
    wire shift_in   = external_clock_select ? sampled : din_sync[1];
    wire overflow   = count_evt & (counter_value == `COUNT_MAX);
    wire start_seen = two_wire & din_prev & ~din_sync[1] & scl_sync[1];

    // latch open in the half after the shift edge, or always with an internal clock
    wire latch_open = ~external_clock_select
                      | (scl_sync[1] == clock_edge_select);

    serial_shift_pkg::shift_word_t next_data;
    serial_shift_pkg::edge_count_t next_count;
    logic                          latch_bit;
    logic                          port_clock;
    logic                          clock_hold;

    always_comb
    begin
        next_data = data_shift_register;
        if (data_write)
            next_data = data_write_value;
        else if (do_shift)
            next_data = {data_shift_register[`MSB_INDEX-1:0], shift_in};
    end

    always_comb
    begin
        next_count = counter_value;
        if (status_write)
            next_count = status_write_count;
        else if (count_evt)
            next_count = counter_value + `COUNT_ONE;
    end

    // shift register, sample and counter
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            data_shift_register <= `DATA_RESET;
            receive_buffer_copy <= `DATA_RESET;
            counter_value       <= `COUNT_ZERO;
            sampled             <= 1'b0;
        end
        else
        begin
            data_shift_register <= next_data;
            counter_value       <= next_count;
            if (sample_evt)
                sampled <= sample_bit;
            if (overflow)
                receive_buffer_copy <= next_data;
        end
    end

    // flags: hardware set wins over software clear
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            counter_overflow_flag <= 1'b0;
            start_flag            <= 1'b0;
        end
        else
        begin
            if (overflow)
                counter_overflow_flag <= 1'b1;
            else if (status_write & status_clear_overflow)
                counter_overflow_flag <= 1'b0;
            if (start_seen)
                start_flag <= 1'b1;
            else if (status_write & status_clear_start)
                start_flag <= 1'b0;
        end
    end

    // pins, latch, clock toggle and hold
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            latch_bit        <= 1'b0;
            port_clock       <= 1'b0;
            clock_hold       <= 1'b0;
            data_out         <= 1'b0;
            data_out_en      <= 1'b0;
            sda_out          <= 1'b0;
            sda_oe           <= 1'b0;
            serial_clock_out <= 1'b0;
            serial_clock_oe  <= 1'b0;
            overflow_irq     <= 1'b0;
            start_irq        <= 1'b0;
        end
        else
        begin
            if (latch_open)
                latch_bit <= next_data[`MSB_INDEX];
            if (toggle_clk)
                port_clock <= ~port_clock;
            if (two_wire & (start_seen | (overflow & hold_on_ovf)))
                clock_hold <= 1'b1;
            else if (~two_wire | (status_write & (status_clear_start | status_clear_overflow)))
                clock_hold <= 1'b0;
            data_out         <= latch_bit;
            data_out_en      <= data_out_dir & (wire_mode == serial_shift_pkg::wire_three);
            sda_out          <= 1'b0;
            sda_oe           <= two_wire & data_out_dir & ~latch_bit;
            serial_clock_out <= port_clock & ~clock_hold;
            serial_clock_oe  <= (clock_pin_dir & (~two_wire | ~port_clock)) | clock_hold;
            overflow_irq     <= counter_overflow_flag & overflow_irq_enable;
            start_irq        <= start_flag & start_irq_enable;
        end
    end

    // checks
    property p_write_beats_shift;
        @(posedge ref_clk) disable iff (reset)
        data_write |=> data_shift_register == $past(data_write_value);
    endproperty
    a_write_beats_shift: assert property (p_write_beats_shift)
        else $error("shift register lost a software write");

    property p_overflow_sets_flag;
        @(posedge ref_clk) disable iff (reset)
        overflow |=> counter_overflow_flag && counter_value == `COUNT_ZERO;
    endproperty
    a_overflow_sets_flag: assert property (p_overflow_sets_flag)
        else $error("overflow did not set flag and wrap");

    property p_buffer_copy;
        @(posedge ref_clk) disable iff (reset)
        overflow |=> receive_buffer_copy == data_shift_register;
    endproperty
    a_buffer_copy: assert property (p_buffer_copy)
        else $error("receive copy not loaded at completion");

    property p_status_clear;
        @(posedge ref_clk) disable iff (reset)
        status_write && status_clear_overflow && !overflow
            && status_write_count == `COUNT_ZERO
        |=> !counter_overflow_flag && counter_value == `COUNT_ZERO;
    endproperty
    a_status_clear: assert property (p_status_clear)
        else $error("flag clear write did not clear flag and counter");

    property p_set_wins;
        @(posedge ref_clk) disable iff (reset)
        overflow && status_write && status_clear_overflow |=> counter_overflow_flag;
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("overflow lost to a simultaneous clear");

    property p_count_step;
        @(posedge ref_clk) disable iff (reset)
        count_evt && !status_write |=> counter_value == $past(counter_value) + `COUNT_ONE;
    endproperty
    a_count_step: assert property (p_count_step)
        else $error("counter did not step with the shift clock");

    property p_toggle_pin;
        @(posedge ref_clk) disable iff (reset)
        toggle_clk && !clock_hold ##1 !clock_hold
        |=> serial_clock_out != $past(serial_clock_out);
    endproperty
    a_toggle_pin: assert property (p_toggle_pin)
        else $error("clock toggle strobe did not move the clock pin");

    property p_latch_internal;
        @(posedge ref_clk) disable iff (reset)
        !external_clock_select |=> latch_bit == data_shift_register[`MSB_INDEX];
    endproperty
    a_latch_internal: assert property (p_latch_internal)
        else $error("output latch not transparent under internal clock");

    property p_irq_follows;
        @(posedge ref_clk) disable iff (reset)
        counter_overflow_flag && overflow_irq_enable |=> overflow_irq;
    endproperty
    a_irq_follows: assert property (p_irq_follows)
        else $error("overflow interrupt not raised");

    property p_hold_after_start;
        @(posedge ref_clk) disable iff (reset)
        start_seen |=> clock_hold ##1 serial_clock_oe && !serial_clock_out;
    endproperty
    a_hold_after_start: assert property (p_hold_after_start)
        else $error("clock not held low after start");

    property p_start_irq;
        @(posedge ref_clk) disable iff (reset)
        start_seen && start_irq_enable ##1 start_irq_enable |=> start_irq;
    endproperty
    a_start_irq: assert property (p_start_irq)
        else $error("start interrupt not raised");

    c_overflow: cover property (@(posedge ref_clk) disable iff (reset) overflow);
    c_ext_shift: cover property (@(posedge ref_clk) disable iff (reset)
        external_clock_select && do_shift);
    c_start: cover property (@(posedge ref_clk) disable iff (reset) start_seen);
    c_write_and_shift: cover property (@(posedge ref_clk) disable iff (reset)
        data_write && do_shift);

endmodule : universal_shift_unit

// ===== verilog/serial_shift_cfg.svh
// constants for the universal shift unit: widths, reset values, counter limits
// assumes inclusion by bare name from the package and the design file
`ifndef SERIAL_SHIFT_CFG_SVH
`define SERIAL_SHIFT_CFG_SVH

`define SHIFT_WIDTH        8
`define COUNT_WIDTH        4
`define COUNT_MAX          4'hF
`define COUNT_ZERO         4'h0
`define COUNT_ONE          4'h1
`define DATA_RESET         8'h00
`define MSB_INDEX          7
`define WIRE_MODE_WIDTH    2
`define WIRE_OFF           2'h0
`define WIRE_THREE         2'h1
`define WIRE_TWO           2'h2
`define WIRE_TWO_HOLD      2'h3

`endif

// ===== verilog/serial_shift_pkg.sv
// types shared by the universal shift unit
// assumes serial_shift_cfg.svh on the include path
`include "serial_shift_cfg.svh"

package serial_shift_pkg;

    typedef enum logic [`WIRE_MODE_WIDTH-1:0] {
        wire_off      = `WIRE_OFF,
        wire_three    = `WIRE_THREE,
        wire_two      = `WIRE_TWO,
        wire_two_hold = `WIRE_TWO_HOLD
    } wire_mode_t;

    typedef logic [`SHIFT_WIDTH-1:0] shift_word_t;
    typedef logic [`COUNT_WIDTH-1:0] edge_count_t;

endpackage : serial_shift_pkg

// ===== sim/spi_master_model.sv
// partner model: an spi master on the far side of the three-wire pins
// assumes the bench resolves the clock pin from sck_en and the design's own enable
`timescale 1ns/1ns

module spi_master_model
(
    // clock pin drive
    output logic      sck_drive,
    output logic      sck_en,
    // data lines
    output logic      mosi,
    input  wire logic miso
);
    localparam int HALF_NS = 500;

    initial
    begin
        sck_drive = 1'b0;
        sck_en    = 1'b1;
        mosi      = 1'b0;
    end

    // the link side leaves reset only on a running clock
    task automatic run_free(input int edges);
        repeat (edges)
            #40 sck_drive = ~sck_drive;
    endtask : run_free

    task automatic set_line(input logic v);
        mosi = v;
    endtask : set_line

    task automatic hand_over(input logic own);
        sck_en = own;
    endtask : hand_over

    // one byte msb first; mode 1 changes data on the rise and samples on the fall
    task automatic transfer(input logic mode, input serial_shift_pkg::shift_word_t tx,
                            output serial_shift_pkg::shift_word_t rx);
        for (int i = 7; i >= 0; i--)
        begin
            if (!mode)
                mosi = tx[i];
            #HALF_NS sck_drive = 1'b1;
            if (mode)
                mosi = tx[i];
            else
                rx[i] = miso;
            #HALF_NS sck_drive = 1'b0;
            if (mode)
                rx[i] = miso;
        end
        // a released line shows the inverse of its last level
        mosi = ~mosi;
    endtask : transfer

    // data falls while the clock is high, then the clock falls
    task automatic start_cond();
        mosi = 1'b1;
        #HALF_NS sck_drive = 1'b1;
        #HALF_NS mosi = 1'b0;
        #HALF_NS sck_drive = 1'b0;
        #HALF_NS mosi = 1'b1;
    endtask : start_cond
endmodule : spi_master_model

// ===== sim/tb.sv
// self-checking bench for the universal shift unit with an spi master partner
// assumes the design files and spi_master_model are compiled before it
`timescale 1ns/1ns

module tb;
    logic ref_clk, reset, data_out_dir, clock_pin_dir, external_clock_select;
    logic clock_edge_select, start_irq_enable, overflow_irq_enable, control_write;
    logic software_clock_strobe, clock_toggle_strobe, timer0_match, data_write;
    logic status_write, status_clear_start, status_clear_overflow;
    logic data_out, data_out_en, sda_out, sda_oe, serial_clock_out, serial_clock_oe;
    logic counter_overflow_flag, start_flag, overflow_irq, start_irq;
    logic sck_drive, sck_en, mosi, link_clk, serial_clock_level, serial_data_in;
    serial_shift_pkg::wire_mode_t  wire_mode;
    serial_shift_pkg::shift_word_t data_write_value, data_shift_register;
    serial_shift_pkg::shift_word_t receive_buffer_copy, rx;
    serial_shift_pkg::edge_count_t status_write_count, counter_value;
    int                            failures, num_checks;

    // the design's enable wins the clock pin, then the partner, else a pull-up
    assign link_clk = serial_clock_oe ? serial_clock_out : (sck_en ? sck_drive : 1'b1);
    assign serial_clock_level = link_clk;
    assign serial_data_in = sda_oe ? 1'b0 : mosi;

    universal_shift_unit dut_u
    (
        .ref_clk, .reset, .link_clk, .serial_data_in, .serial_clock_level, .data_out,
        .data_out_en, .sda_out, .sda_oe, .serial_clock_out, .serial_clock_oe, .data_out_dir,
        .clock_pin_dir, .wire_mode, .external_clock_select, .clock_edge_select,
        .start_irq_enable, .overflow_irq_enable, .control_write, .software_clock_strobe,
        .clock_toggle_strobe, .timer0_match, .data_write, .data_write_value, .status_write,
        .status_clear_start, .status_clear_overflow, .status_write_count,
        .data_shift_register, .receive_buffer_copy, .counter_value, .counter_overflow_flag,
        .start_flag, .overflow_irq, .start_irq
    );

    spi_master_model partner_u
    (
        .sck_drive, .sck_en, .mosi, .miso(data_out_en ? data_out : 1'b1)
    );

    initial
    begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : tick

    task automatic chk(input serial_shift_pkg::shift_word_t got,
                       input serial_shift_pkg::shift_word_t exp, input string what);
        num_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic wr_data(input serial_shift_pkg::shift_word_t v);
        data_write       = 1'b1;
        data_write_value = v;
        tick(1);
        data_write = 1'b0;
        tick(1);
    endtask : wr_data

    task automatic wr_status(input logic clr_ovf, input logic clr_start,
                             input serial_shift_pkg::edge_count_t cnt);
        status_write          = 1'b1;
        status_clear_overflow = clr_ovf;
        status_clear_start    = clr_start;
        status_write_count    = cnt;
        tick(1);
        status_write = 1'b0;
        tick(1);
    endtask : wr_status

    task automatic wr_ctrl(input logic strobe, input logic toggle);
        control_write         = 1'b1;
        software_clock_strobe = strobe;
        clock_toggle_strobe   = toggle;
        tick(1);
        control_write = 1'b0;
        tick(1);
    endtask : wr_ctrl

    task automatic complete_run();
        $display("checks %0d, mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : complete_run

    initial
    begin
        #300000;
        failures++;
        $display("[ERR] %0t watchdog expired", $time);
        complete_run();
    end

    initial
    begin
        failures   = 0;
        num_checks = 0;
        wire_mode  = serial_shift_pkg::wire_off;
        {data_out_dir, clock_pin_dir, external_clock_select, clock_edge_select,
         start_irq_enable, overflow_irq_enable, control_write, software_clock_strobe,
         clock_toggle_strobe, timer0_match, data_write, status_write, status_clear_start,
         status_clear_overflow, data_write_value, status_write_count} = '0;
        reset = 1'b1;
        fork
            partner_u.run_free(32);
            begin
                repeat (10) @(posedge ref_clk);
                #1 reset = 1'b0;
            end
        join
        tick(5);
        chk(data_shift_register, 8'h00, "reset data");
        chk({4'h0, counter_value}, 8'h00, "reset count");
        $display("reset test done");

        wire_mode    = serial_shift_pkg::wire_three;
        data_out_dir = 1'b1;
        wr_data(8'h80);
        tick(1);
        chk(data_shift_register, 8'h80, "data write");
        chk({7'h00, data_out}, 8'h01, "msb through open latch");
        chk({6'h00, data_out_en, sda_oe}, 8'h02, "three-wire output pin");
        $display("output pin test done");

        wr_data(8'h00);
        partner_u.set_line(1'b1);
        wr_status(1'b1, 1'b0, 4'h0);
        wr_ctrl(1'b1, 1'b0);
        chk(data_shift_register, 8'h01, "strobe shift");
        chk({4'h0, counter_value}, 8'h01, "strobe count");
        clock_edge_select = 1'b1;
        timer0_match      = 1'b1;
        tick(1);
        timer0_match = 1'b0;
        tick(1);
        chk(data_shift_register, 8'h03, "timer shift");
        chk({4'h0, counter_value}, 8'h02, "timer count");
        clock_edge_select     = 1'b0;
        control_write         = 1'b1;
        software_clock_strobe = 1'b1;
        data_write            = 1'b1;
        data_write_value      = 8'h5A;
        tick(1);
        control_write = 1'b0;
        data_write    = 1'b0;
        tick(1);
        chk(data_shift_register, 8'h5A, "write beats shift");
        $display("internal clock test done");

        wr_status(1'b1, 1'b0, 4'hF);
        chk({4'h0, counter_value}, 8'h0F, "count write");
        overflow_irq_enable = 1'b1;
        wr_ctrl(1'b1, 1'b0);
        chk({4'h0, counter_value}, 8'h00, "count wraps");
        chk({6'h00, counter_overflow_flag, overflow_irq}, 8'h03, "overflow irq");
        wr_status(1'b1, 1'b0, 4'h0);
        chk({3'h0, counter_overflow_flag, counter_value}, 8'h00, "flag clear");
        $display("counter test done");

        external_clock_select = 1'b1;
        wr_ctrl(1'b0, 1'b0);
        wr_data(8'h3C);
        wr_status(1'b1, 1'b0, 4'h0);
        partner_u.transfer(1'b0, 8'hC5, rx);
        tick(6);
        chk(rx, 8'h3C, "slave byte at master");
        chk(data_shift_register, 8'hC5, "master byte at slave");
        chk(receive_buffer_copy, 8'hC5, "receive copy");
        chk({3'h0, counter_overflow_flag, counter_value}, 8'h10, "sixteen edges");
        clock_edge_select = 1'b1;
        wr_status(1'b1, 1'b0, 4'h0);
        partner_u.transfer(1'b1, 8'h96, rx);
        tick(6);
        chk({3'h0, counter_overflow_flag, counter_value}, 8'h10, "mode 1 edges");
        $display("slave transfer test done");

        clock_edge_select = 1'b0;
        clock_pin_dir     = 1'b1;
        tick(3);
        partner_u.hand_over(1'b0);
        wr_status(1'b1, 1'b0, 4'h0);
        for (int k = 0; k < 16; k++)
        begin
            wr_ctrl(1'b1, 1'b1);
            tick(6);
            if (k == 0)
                chk({7'h00, serial_clock_out}, 8'h01, "pin toggled");
        end
        chk({3'h0, counter_overflow_flag, counter_value}, 8'h10, "sixteen writes");
        external_clock_select = 1'b0;
        wr_status(1'b1, 1'b0, 4'h0);
        control_write       = 1'b1;
        clock_toggle_strobe = 1'b1;
        for (int k = 0; k < 8; k++)
        begin
            software_clock_strobe = k[0];
            tick(1);
            if (k == 1)
                chk({7'h00, serial_clock_out}, 8'h01, "pin at half rate");
        end
        control_write = 1'b0;
        tick(2);
        chk({4'h0, counter_value}, 8'h04, "half-rate strobes");
        partner_u.hand_over(1'b1);
        clock_pin_dir = 1'b0;
        $display("master strobe test done");

        wire_mode        = serial_shift_pkg::wire_two;
        data_out_dir     = 1'b0;
        start_irq_enable = 1'b1;
        wr_status(1'b1, 1'b1, 4'h0);
        partner_u.start_cond();
        tick(4);
        chk({5'h00, start_flag, start_irq, serial_clock_oe}, 8'h07, "start hold");
        wr_status(1'b1, 1'b1, 4'h0);
        tick(1);
        chk({7'h00, start_flag}, 8'h00, "start cleared");
        wire_mode = serial_shift_pkg::wire_two_hold;
        wr_status(1'b1, 1'b1, 4'hF);
        wr_ctrl(1'b1, 1'b1);
        chk({6'h00, counter_overflow_flag, serial_clock_oe}, 8'h03, "hold after overflow");
        $display("start condition test done");
        complete_run();
    end
endmodule : tb
